// ==== adc_control_register_bank.sv ====
// adc register bank with wishbone slave, protection, sync handshake and interrupts
//
// Summary of operation
// - 8, 16 and 32 bit accesses via byte selects; registers 8/16/32 bits.
// - every byte lane of a register is written on its own; reads return the whole word.
// - write-protected registers ignore writes while access controller protects.
// - enable-protected registers ignore writes while the converter is enabled.
// - keep-running bit 2 of control_a keeps converter alive in standby.
// - enable bit reads back at once; actual enable follows after sync.
// - soft reset returns all but debug_control to reset and disables.
// - a write setting soft reset discards all other bits written.
// - soft reset reads one until done; it and sync busy clear together.
// - reference_control bit 7 drives reference buffer offset compensation.
// - enable set writes of one enable, enable clear writes disable.
// - flags set on event, clear on written one; irq while flag and enable.
// - synced access while busy stalls the bus, then completes normally.
// - control bits and listed registers pass a sync delay with busy set.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module adc_control_register_bank #(
  parameter int SYNC_CYCLES = adc_regs_pkg::SYNC_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               access_protect,
  input  wire logic               standby_sleep,
  input  wire logic               result_ready_in,
  input  wire logic               overrun_in,
  input  wire logic               window_match_in,
  input  wire logic [15:0]        result_value,
  input  wire logic               start_event_in,
  output logic                    irq,
  output logic                    converter_enabled,
  output logic                    converter_run,
  output logic                    ref_buffer_offset_comp,
  output adc_regs_pkg::adc_config_t config_out,
  output logic                    start_pulse,
  output logic                    flush_pulse,
  output logic                    result_ready_event,
  output logic                    window_match_event
);

  typedef struct packed {
    // every word of the map; bits outside write_mask never leave zero
    logic [adc_regs_pkg::NREG-1:0][31:0] regs;
    // ack and read data launch from the same edge
    logic                                ack;
    logic [31:0]                         rdata;
    // control_a bit 0 view while the reset crosses over
    logic                                soft_reset_pending;
    // start and flush wait here until the crossing completes
    logic [1:0]                          trigger_pending;
    // actual enable, lags the stored enable bit by the sync delay
    logic                                enabled;
    logic                                start_p;
    logic                                flush_p;
    logic                                rr_event;
    logic                                wm_event;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  logic        sync_start;
  logic        sync_busy_a;
  logic        sync_done;
  logic        request;
  logic        stall;
  logic        in_map;
  logic        allowed;
  logic [5:0]  idx;
  logic [31:0] lanes;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [3:0]  irq_enables;
  logic [3:0]  irq_flags;
  logic [3:0]  irq_pending;
  logic        take;
  logic        commit;
  logic        soft_reset_write;

  // one shared crossing: a second synced access stalls rather than queues
  sync_delay #(
    .CYCLES (SYNC_CYCLES)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (sync_start),
    .busy   (sync_busy_a),
    .done   (sync_done)
  );

  assign request = wb_cyc_i && wb_stb_i;
  assign idx     = wb_adr_i[7:2];
  assign in_map  = idx < 6'(adc_regs_pkg::NREG);
  assign wdata   = wb_dat_i;

  // accepted request: ack and read data follow on the next edge
  assign take = request && !state.ack && !stall;
  // write lands on the edge where the master samples ack; a protected
  // or unmapped target still gets its ack, never an error
  assign commit = request && state.ack && wb_we_i && in_map && allowed;
  assign soft_reset_write = commit && (idx == adc_regs_pkg::CONTROL_A_IDX)
    && wb_sel_i[0] && wdata[adc_regs_pkg::SOFT_RESET_BIT];

  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign lanes[8*lane +: 8] = {8{wb_sel_i[lane]}};
  end
  assign wmask = lanes & adc_regs_pkg::write_mask(idx);

  assign allowed = !(adc_regs_pkg::write_protected(idx) && access_protect)
    && !(adc_regs_pkg::enable_protected(idx)
         && (state.enabled || state.regs[adc_regs_pkg::CONTROL_A_IDX][adc_regs_pkg::ENABLE_BIT]));

  // status and plain registers never stall, so software can poll busy
  // stall synced access while busy
  assign stall = sync_busy_a && (wb_we_i ? adc_regs_pkg::write_synced(idx)
                                          : adc_regs_pkg::read_synced(idx));

  assign irq_enables = state.regs[adc_regs_pkg::IRQ_ENABLE_SET_IDX][3:0];
  assign irq_flags   = state.regs[adc_regs_pkg::IRQ_FLAGS_IDX][3:0];

  // read mux runs at take time; a stalled read sees the settled value
  function automatic logic [31:0] read_value(input bank_state_t s,
                                             input logic [5:0] i,
                                             input logic map_hit,
                                             input logic busy,
                                             input logic [15:0] result);
    read_value = 32'h0000_0000;
    if (map_hit) begin
      case (i)
        adc_regs_pkg::CONTROL_A_IDX: begin
          read_value = s.regs[i] | {31'h0000_0000, s.soft_reset_pending};
        end
        adc_regs_pkg::IRQ_ENABLE_CLEAR_IDX: begin
          read_value = s.regs[adc_regs_pkg::IRQ_ENABLE_SET_IDX];
        end
        adc_regs_pkg::SYNC_STATUS_IDX: begin
          read_value = {24'h00_0000, busy, 7'h00};
        end
        adc_regs_pkg::RESULT_IDX: begin
          read_value = {16'h0000, result};
        end
        adc_regs_pkg::SOFTWARE_TRIGGER_IDX: begin
          read_value = {30'h0000_0000, s.trigger_pending};
        end
        default: begin
          read_value = s.regs[i];
        end
      endcase
    end
  endfunction

  always_comb begin
    next_state          = state;
    next_state.ack      = 1'b0;
    next_state.start_p  = 1'b0;
    next_state.flush_p  = 1'b0;
    sync_start          = 1'b0;

    // answer one cycle after the request is taken, data registered with ack
    if (take) begin
      next_state.ack   = 1'b1;
      next_state.rdata = read_value(state, idx, in_map, sync_busy_a, result_value);
    end

    // write commits at the edge where the master samples ack
    if (commit) begin
      if (soft_reset_write) begin
        next_state.soft_reset_pending = 1'b1;
        sync_start                    = 1'b1;
      end else begin
        case (idx)
          adc_regs_pkg::IRQ_ENABLE_CLEAR_IDX: begin
            next_state.regs[adc_regs_pkg::IRQ_ENABLE_SET_IDX] =
              state.regs[adc_regs_pkg::IRQ_ENABLE_SET_IDX] & ~(wdata & wmask);
          end
          adc_regs_pkg::IRQ_ENABLE_SET_IDX: begin
            next_state.regs[idx] = state.regs[idx] | (wdata & wmask);
          end
          adc_regs_pkg::IRQ_FLAGS_IDX: begin
            next_state.regs[idx] = state.regs[idx] & ~(wdata & wmask);
          end
          adc_regs_pkg::SOFTWARE_TRIGGER_IDX: begin
            next_state.trigger_pending = state.trigger_pending | wdata[1:0] & wmask[1:0];
            sync_start                 = |wmask[1:0];
          end
          adc_regs_pkg::SYNC_STATUS_IDX,
          adc_regs_pkg::RESULT_IDX: begin
            next_state.regs[idx] = state.regs[idx];
          end
          default: begin
            next_state.regs[idx] = (state.regs[idx] & ~wmask) | (wdata & wmask);
            sync_start = adc_regs_pkg::write_synced(idx) && (|wmask);
          end
        endcase
      end
    end

    if (sync_done) begin
      if (state.soft_reset_pending) begin
        // all but debug_control reset
        // flags and enables go too; sync ready, set on this same edge, marks the end
        next_state.regs = '0;
        next_state.regs[adc_regs_pkg::DEBUG_CONTROL_IDX] =
          state.regs[adc_regs_pkg::DEBUG_CONTROL_IDX];
        next_state.enabled            = 1'b0;
        next_state.trigger_pending    = 2'b00;
        next_state.soft_reset_pending = 1'b0;
      end else begin
        // start and flush leave as pulses on the edge after done
        // actual enable changes late
        next_state.enabled =
          state.regs[adc_regs_pkg::CONTROL_A_IDX][adc_regs_pkg::ENABLE_BIT];
        next_state.start_p         = state.trigger_pending[adc_regs_pkg::START_BIT];
        next_state.flush_p         = state.trigger_pending[adc_regs_pkg::FLUSH_BIT];
        next_state.trigger_pending = 2'b00;
      end
    end

    // input event already lives on this clock: no crossing, no stall
    if (start_event_in
        && state.regs[adc_regs_pkg::EVENT_CONTROL_IDX][adc_regs_pkg::START_EI_BIT]) begin
      next_state.start_p = 1'b1;
    end

    next_state.rr_event = result_ready_in
      && state.regs[adc_regs_pkg::EVENT_CONTROL_IDX][adc_regs_pkg::RESULT_READY_EO_BIT];
    next_state.wm_event = window_match_in
      && state.regs[adc_regs_pkg::EVENT_CONTROL_IDX][adc_regs_pkg::WINDOW_EO_BIT];

    if (result_ready_in) begin
      next_state.regs[adc_regs_pkg::IRQ_FLAGS_IDX][adc_regs_pkg::RESULT_READY_BIT] = 1'b1;
    end
    if (overrun_in) begin
      next_state.regs[adc_regs_pkg::IRQ_FLAGS_IDX][adc_regs_pkg::OVERRUN_BIT] = 1'b1;
    end
    if (window_match_in) begin
      next_state.regs[adc_regs_pkg::IRQ_FLAGS_IDX][adc_regs_pkg::WINDOW_MATCH_BIT] = 1'b1;
    end
    if (sync_done) begin
      next_state.regs[adc_regs_pkg::IRQ_FLAGS_IDX][adc_regs_pkg::SYNC_READY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign wb_dat_o  = state.rdata;
  assign wb_ack_o  = state.ack;

  for (genvar src = 0; src < adc_regs_pkg::IRQ_BITS; src++) begin : g_irq
    assign irq_pending[src] = irq_flags[src] && irq_enables[src];
  end
  // level output: stays up until the flag or its enable goes
  assign irq = |irq_pending;

  assign converter_enabled = state.enabled;
  assign converter_run = state.enabled && (!standby_sleep
    || state.regs[adc_regs_pkg::CONTROL_A_IDX][adc_regs_pkg::KEEP_RUNNING_BIT]);
  assign ref_buffer_offset_comp =
    state.regs[adc_regs_pkg::REFERENCE_CONTROL_IDX][adc_regs_pkg::REF_COMP_BIT];

  assign start_pulse        = state.start_p;
  assign flush_pulse        = state.flush_p;
  assign result_ready_event = state.rr_event;
  assign window_match_event = state.wm_event;

  // field views for the converter side; widths follow the package carrier
  always_comb begin
    config_out.reference_select       = state.regs[adc_regs_pkg::REFERENCE_CONTROL_IDX][3:0];
    config_out.averaging              = state.regs[adc_regs_pkg::AVERAGING_CONTROL_IDX][6:0];
    config_out.sample_time            = state.regs[adc_regs_pkg::SAMPLE_TIME_IDX][5:0];
    config_out.control_b              = state.regs[adc_regs_pkg::CONTROL_B_IDX][10:0];
    config_out.window_mode            = state.regs[adc_regs_pkg::WINDOW_CONTROL_IDX][2:0];
    config_out.input_selection        = state.regs[adc_regs_pkg::INPUT_SELECTION_IDX][27:0];
    config_out.window_lower_threshold = state.regs[adc_regs_pkg::WINDOW_LOWER_IDX][15:0];
    config_out.window_upper_threshold = state.regs[adc_regs_pkg::WINDOW_UPPER_IDX][15:0];
    config_out.gain_correction        = state.regs[adc_regs_pkg::GAIN_CORRECTION_IDX][11:0];
    config_out.offset_correction      = state.regs[adc_regs_pkg::OFFSET_CORRECTION_IDX][11:0];
    config_out.calibration            = state.regs[adc_regs_pkg::CALIBRATION_IDX][10:0];
    config_out.debug_run              = state.regs[adc_regs_pkg::DEBUG_CONTROL_IDX][0];
  end

endmodule

// ==== adc_regs_pkg.sv ====
// register map, field positions, reset values and carrier types of the adc register bank
package adc_regs_pkg;

  // word index of each register; byte address is four times the index
  localparam logic [5:0] CONTROL_A_IDX        = 6'h00;
  localparam logic [5:0] REFERENCE_CONTROL_IDX = 6'h01;
  localparam logic [5:0] AVERAGING_CONTROL_IDX = 6'h02;
  localparam logic [5:0] SAMPLE_TIME_IDX      = 6'h03;
  localparam logic [5:0] CONTROL_B_IDX        = 6'h04;
  localparam logic [5:0] WINDOW_CONTROL_IDX   = 6'h08;
  localparam logic [5:0] SOFTWARE_TRIGGER_IDX = 6'h0C;
  localparam logic [5:0] INPUT_SELECTION_IDX  = 6'h10;
  localparam logic [5:0] EVENT_CONTROL_IDX    = 6'h14;
  localparam logic [5:0] IRQ_ENABLE_CLEAR_IDX = 6'h16;
  localparam logic [5:0] IRQ_ENABLE_SET_IDX   = 6'h17;
  localparam logic [5:0] IRQ_FLAGS_IDX        = 6'h18;
  localparam logic [5:0] SYNC_STATUS_IDX      = 6'h19;
  localparam logic [5:0] RESULT_IDX           = 6'h1A;
  localparam logic [5:0] WINDOW_LOWER_IDX     = 6'h1C;
  localparam logic [5:0] WINDOW_UPPER_IDX     = 6'h20;
  localparam logic [5:0] GAIN_CORRECTION_IDX  = 6'h24;
  localparam logic [5:0] OFFSET_CORRECTION_IDX = 6'h26;
  localparam logic [5:0] CALIBRATION_IDX      = 6'h28;
  localparam logic [5:0] DEBUG_CONTROL_IDX    = 6'h2A;
  localparam int         NREG                 = 43;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // control_a fields
  localparam int SOFT_RESET_BIT      = 0;
  localparam int ENABLE_BIT          = 1;
  localparam int KEEP_RUNNING_BIT    = 2;
  // reference_control fields
  localparam int REF_COMP_BIT        = 7;
  // sync_status fields
  localparam int SYNC_BUSY_BIT       = 7;
  // software_trigger fields
  localparam int FLUSH_BIT           = 0;
  localparam int START_BIT           = 1;
  // event_control fields
  localparam int START_EI_BIT        = 0;
  localparam int RESULT_READY_EO_BIT = 4;
  localparam int WINDOW_EO_BIT       = 5;
  // shared bit order of irq_flags, irq_enable_set and irq_enable_clear
  localparam int RESULT_READY_BIT    = 0;
  localparam int OVERRUN_BIT         = 1;
  localparam int WINDOW_MATCH_BIT    = 2;
  localparam int SYNC_READY_BIT      = 3;
  localparam int IRQ_BITS            = 4;

  // cycles a write spends crossing into the converter side
  localparam int SYNC_CYCLES = 4;

  typedef struct packed {
    logic [3:0]  reference_select;
    logic [6:0]  averaging;
    logic [5:0]  sample_time;
    logic [10:0] control_b;
    logic [2:0]  window_mode;
    logic [27:0] input_selection;
    logic [15:0] window_lower_threshold;
    logic [15:0] window_upper_threshold;
    logic [11:0] gain_correction;
    logic [11:0] offset_correction;
    logic [10:0] calibration;
    logic        debug_run;
  } adc_config_t;

  // writable bits of each register; all others ignore writes and read zero, except sync_status bit 7 and result bits 15:0
  function automatic logic [31:0] write_mask(input logic [5:0] idx);
    case (idx)
      CONTROL_A_IDX:         write_mask = 32'h0000_0007;
      REFERENCE_CONTROL_IDX: write_mask = 32'h0000_008F;
      AVERAGING_CONTROL_IDX: write_mask = 32'h0000_007F;
      SAMPLE_TIME_IDX:       write_mask = 32'h0000_003F;
      CONTROL_B_IDX:         write_mask = 32'h0000_073F;
      WINDOW_CONTROL_IDX:    write_mask = 32'h0000_0007;
      SOFTWARE_TRIGGER_IDX:  write_mask = 32'h0000_0003;
      INPUT_SELECTION_IDX:   write_mask = 32'h0FFF_1F1F;
      EVENT_CONTROL_IDX:     write_mask = 32'h0000_0033;
      IRQ_ENABLE_CLEAR_IDX,
      IRQ_ENABLE_SET_IDX,
      IRQ_FLAGS_IDX:         write_mask = 32'h0000_000F;
      WINDOW_LOWER_IDX,
      WINDOW_UPPER_IDX:      write_mask = 32'h0000_FFFF;
      GAIN_CORRECTION_IDX,
      OFFSET_CORRECTION_IDX: write_mask = 32'h0000_0FFF;
      CALIBRATION_IDX:       write_mask = 32'h0000_07FF;
      DEBUG_CONTROL_IDX:     write_mask = 32'h0000_0001;
      default:               write_mask = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic write_protected(input logic [5:0] idx);
    write_protected = idx inside {CONTROL_A_IDX, REFERENCE_CONTROL_IDX,
      AVERAGING_CONTROL_IDX, SAMPLE_TIME_IDX, CONTROL_B_IDX, WINDOW_CONTROL_IDX,
      INPUT_SELECTION_IDX, EVENT_CONTROL_IDX, WINDOW_LOWER_IDX, WINDOW_UPPER_IDX,
      GAIN_CORRECTION_IDX, OFFSET_CORRECTION_IDX, CALIBRATION_IDX, DEBUG_CONTROL_IDX};
  endfunction

  function automatic logic enable_protected(input logic [5:0] idx);
    enable_protected = idx inside {AVERAGING_CONTROL_IDX, SAMPLE_TIME_IDX,
      CALIBRATION_IDX};
  endfunction

  function automatic logic write_synced(input logic [5:0] idx);
    write_synced = idx inside {CONTROL_A_IDX, CONTROL_B_IDX, SOFTWARE_TRIGGER_IDX,
      WINDOW_CONTROL_IDX, INPUT_SELECTION_IDX, WINDOW_LOWER_IDX, WINDOW_UPPER_IDX};
  endfunction

  function automatic logic read_synced(input logic [5:0] idx);
    read_synced = idx inside {SOFTWARE_TRIGGER_IDX, INPUT_SELECTION_IDX};
  endfunction

endpackage

// ==== sync_delay.sv ====
// fixed-length crossing delay with busy level and completion pulse
`timescale 1ns/10ps
module sync_delay #(
  parameter int CYCLES = adc_regs_pkg::SYNC_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  typedef struct packed {
    logic       busy;
    logic [7:0] count;
  } delay_state_t;

  delay_state_t state;
  delay_state_t next_state;

  localparam logic [7:0] LAST = 8'(CYCLES - 1);

  always_comb begin
    next_state = state;
    if (state.busy) begin
      next_state.count = state.count + 8'h01;
      if (state.count == LAST) begin
        next_state.busy = 1'b0;
      end
    end else if (start) begin
      next_state.busy  = 1'b1;
      next_state.count = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign busy = state.busy;
  // busy falls on the same edge that consumes done
  assign done = state.busy && (state.count == LAST);

endmodule

// ==== adc_control_register_bank_checker.sv ====
// port-level assertions for the adc register bank
`timescale 1ns/10ps
module adc_control_register_bank_checker #(
  parameter int SYNC_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        access_protect,
  input wire logic        standby_sleep,
  input wire logic        result_ready_in,
  input wire logic        window_match_in,
  input wire logic        irq,
  input wire logic        converter_enabled,
  input wire logic        converter_run,
  input wire logic        ref_buffer_offset_comp,
  input wire logic        start_pulse,
  input wire logic        result_ready_event,
  input wire logic        window_match_event
);
  // generous bound: sync length plus handshake slack
  localparam int SYNC_MAX = SYNC_CYCLES + 8;
  logic ctrl_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  assign ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && !access_protect;

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a pending request");
  run_gate_a: assert property (converter_run |-> converter_enabled)
    else $error("converter runs while disabled");
  run_awake_a: assert property (converter_enabled && !standby_sleep |-> converter_run)
    else $error("enabled converter halted outside standby");
  enable_delay_a: assert property (ctrl_wr && wb_dat_i[1:0] == 2'b10 && !converter_enabled
    |-> ##1 (!converter_enabled) [*2] ##[1:SYNC_MAX] converter_enabled)
    else $error("enable not applied after sync delay");
  soft_disable_a: assert property (ctrl_wr && wb_dat_i[0]
    |-> ##[1:SYNC_MAX] (!converter_enabled && !ref_buffer_offset_comp))
    else $error("soft reset left converter configured");
  ref_hold_a: assert property ($changed(ref_buffer_offset_comp)
    |-> $past(wb_ack_o && wb_we_i) || !ref_buffer_offset_comp)
    else $error("compensation changed without a write");
  start_pulse_a: assert property (start_pulse |=> !start_pulse)
    else $error("start pulse wider than one cycle");
  result_event_a: assert property (result_ready_event |-> $past(result_ready_in))
    else $error("result event without input pulse");
  window_event_a: assert property (window_match_event |-> $past(window_match_in))
    else $error("window event without input pulse");
  reserved_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h2A
    |-> wb_dat_o == 32'h0000_0000)
    else $error("reserved address read nonzero");
  status_bits_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h19
    |-> wb_dat_o[6:0] == 7'h00)
    else $error("unused status bits read nonzero");

  cover property (ctrl_wr && wb_dat_i[1:0] == 2'b10);
  cover property (ctrl_wr && wb_dat_i[0]);
  cover property ($rose(irq));
endmodule

bind adc_control_register_bank adc_control_register_bank_checker #(.SYNC_CYCLES(SYNC_CYCLES)) chk (
  .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .access_protect(access_protect), .standby_sleep(standby_sleep),
  .result_ready_in(result_ready_in), .window_match_in(window_match_in), .irq(irq),
  .converter_enabled(converter_enabled), .converter_run(converter_run),
  .ref_buffer_offset_comp(ref_buffer_offset_comp), .start_pulse(start_pulse),
  .result_ready_event(result_ready_event), .window_match_event(window_match_event));

// ==== adc_control_register_bank_bench.sv ====
// self-checking bench for the adc register bank
`timescale 1ns/10ps
module adc_control_register_bank_bench;
  logic        clk, arst_n, cyc, stb, we, prot, sleep, start_ev;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rd;
  logic [2:0]  ev;
  logic [31:0] dat_o;
  logic        ack, irq, en, run, comp;
  logic        sp, fp, rre, wme;
  adc_regs_pkg::adc_config_t cfg;
  int          n_mismatch, checked, cycles;

  adc_control_register_bank #(.SYNC_CYCLES(8)) DUT (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .access_protect(prot), .standby_sleep(sleep), .result_ready_in(ev[0]),
    .overrun_in(ev[1]), .window_match_in(ev[2]), .result_value(16'hA5C3),
    .start_event_in(start_ev), .irq(irq), .converter_enabled(en), .converter_run(run),
    .ref_buffer_offset_comp(comp), .config_out(cfg), .start_pulse(sp), .flush_pulse(fp),
    .result_ready_event(rre), .window_match_event(wme));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until ack is sampled high, then released
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {3'b111, a, s, d};
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb, we} <= 3'b000;
    #1;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    {cyc, stb, we, adr, sel} <= {3'b110, a, 4'hF};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
    #1;
    check(what, rd, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 3'(1 << i);
    @(posedge clk);
    ev <= 3'b000;
    #1;
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    {arst_n, cyc, stb, we, prot, sleep, start_ev, adr, sel, dat, ev} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdx(8'h00, 32'h0, "control_a reset");
    rdx(8'h04, 32'h0, "reference_control reset");
    wr(8'h04, 4'h1, 32'hFF);
    rdx(8'h04, 32'h8F, "reference unused bits");
    check("comp on", comp, 1'b1);
    wr(8'h04, 4'h1, 32'h0F);
    check("comp off", comp, 1'b0);
    wr(8'hB0, 4'hF, 32'hFFFF_FFFF);
    rdx(8'hB0, 32'h0, "reserved word");
    rdx(8'h68, 32'h0000_A5C3, "result");
    // back-to-back synced accesses stall rather than fail
    wr(8'h40, 4'hF, 32'hFFFF_FFFF);
    wr(8'h40, 4'h4, 32'h0);
    rdx(8'h40, 32'h0F00_1F1F, "input byte lane");
    wr(8'h40, 4'h3, 32'h0);
    rdx(8'h40, 32'h0F00_0000, "input halfword");
    check("config input", cfg.input_selection, 32'h0F00_0000);
    @(posedge clk);
    prot <= 1'b1;
    wr(8'h04, 4'h1, 32'h80);
    rdx(8'h04, 32'h0F, "protected write");
    wr(8'h5C, 4'h1, 32'h1);
    rdx(8'h5C, 32'h1, "enable set");
    @(posedge clk);
    prot <= 1'b0;
    wr(8'h60, 4'h1, 32'h0F);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      check("irq by source", irq, i == 0);
      rdx(8'h60, 32'h1 << i, "flag order");
      wr(8'h60, 4'h1, 32'h1 << i);
      check("irq after clear", irq, 1'b0);
    end
    wr(8'h5C, 4'h1, 32'h2);
    pulse(1);
    check("irq overrun", irq, 1'b1);
    wr(8'h58, 4'h1, 32'h2);
    check("irq disabled", irq, 1'b0);
    rdx(8'h58, 32'h1, "enable clear view");
    wr(8'h60, 4'h1, 32'h2);
    @(posedge clk);
    sleep <= 1'b1;
    wr(8'h00, 4'h1, 32'h02);
    check("enable delayed", en, 1'b0);
    rdx(8'h00, 32'h02, "enable readback");
    rdx(8'h64, 32'h80, "sync busy");
    repeat (40) if (en !== 1'b1) @(posedge clk);
    check("enabled", en, 1'b1);
    check("halted in standby", run, 1'b0);
    wr(8'h00, 4'h1, 32'h06);
    check("runs in standby", run, 1'b1);
    wr(8'h08, 4'h1, 32'h7F);
    rdx(8'h08, 32'h0, "enable protected");
    rdx(8'h60, 32'h08, "sync ready");
    wr(8'h30, 4'h1, 32'h03);
    repeat (40) if (sp !== 1'b1) @(negedge clk);
    check("start pulse", sp, 1'b1);
    check("flush pulse", fp, 1'b1);
    wr(8'h50, 4'h1, 32'h30);
    pulse(0);
    check("result event", rre, 1'b1);
    pulse(2);
    check("window event", wme, 1'b1);
    wr(8'hA8, 4'h1, 32'h1);
    wr(8'h04, 4'h1, 32'h80);
    wr(8'h00, 4'h1, 32'h05);
    rdx(8'h00, 32'h07, "reset pending");
    repeat (40) if (en !== 1'b0) @(posedge clk);
    rdx(8'h00, 32'h0, "reset done");
    rdx(8'h64, 32'h0, "busy done");
    rdx(8'h04, 32'h0, "reference after reset");
    rdx(8'hA8, 32'h1, "debug kept");
    rdx(8'h5C, 32'h0, "enables after reset");
    rdx(8'h60, 32'h08, "flags after reset");
    check("disabled", en, 1'b0);
    give_verdict();
  end
endmodule
